// ===== ipp_regs.sv
// pending-set, pending-clear and priority registers of the interrupt controller
`timescale 1ns/1ns
`default_nettype none
`include "ipp_cfg.svh"

module ipp_regs
  import ipp_pkg::*;
(
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst,
  // private peripheral bus access port
  input  wire logic                      bus_valid,
  input  wire logic                      bus_write,
  input  wire logic [31:0]               bus_addr,
  input  wire logic [31:0]               bus_wdata,
  output var  logic [31:0]               bus_rdata,
  output var  logic                      bus_ready,
  output var  logic                      bus_err,
  // pending requests from the interrupt sources, same clock
  input  wire logic [`IPP_NUM_IRQ-1:0]   irq_pend_set,
  // state seen by the arbitration logic
  output var  logic [`IPP_NUM_IRQ-1:0]   pending,
  output var  logic [2*`IPP_NUM_IRQ-1:0] priority_flat
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  ipp_state_s state_q;
  ipp_state_s state_d;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  logic                                          hit_set;
  logic                                          hit_clr;
  logic                                          hit_prio;
  logic [`IPP_PRIO_IDX_MSB-`IPP_PRIO_IDX_LSB:0]  prio_idx;
  ipp_word_t [`IPP_NUM_PRIO_REGS-1:0]            prio_word;

  // fixed map, all registers always decoded
  assign hit_set  = (bus_addr == `IPP_PEND_SET_ADDR);
  assign hit_clr  = (bus_addr == `IPP_PEND_CLR_ADDR);
  assign hit_prio = (bus_addr >= `IPP_PRIO_BASE_ADDR) &&
                    (bus_addr <= `IPP_PRIO_LAST_ADDR) &&
                    (bus_addr[1:0] == 2'h0);
  assign prio_idx = bus_addr[`IPP_PRIO_IDX_MSB:`IPP_PRIO_IDX_LSB];

  // ----------------------------------------
  // priority read words
  // ----------------------------------------
  // reserved bits are built as zero, so they never hold state
  genvar gr;
  genvar gf;
  generate
    for (gr = 0; gr < `IPP_NUM_PRIO_REGS; gr = gr + 1)
    begin : g_reg
      for (gf = 0; gf < `IPP_FIELDS_PER_REG; gf = gf + 1)
      begin : g_fld
        assign prio_word[gr][gf*`IPP_BYTE_WIDTH +: `IPP_PRIO_LSB] = '0;
        assign prio_word[gr][gf*`IPP_BYTE_WIDTH+`IPP_PRIO_LSB +: `IPP_PRIO_WIDTH] =
          state_q.prio[gr][gf];
        assign priority_flat[(gr*`IPP_FIELDS_PER_REG+gf)*`IPP_PRIO_WIDTH +: `IPP_PRIO_WIDTH] =
          state_q.prio[gr][gf];
      end
    end
  endgenerate

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    state_d       = state_q;
    state_d.ready = 1'b0;
    state_d.err   = 1'b0;
    state_d.rdata = `IPP_RDATA_RESET;
    if (bus_valid && bus_write && hit_clr)
    begin
      // clear first so a source setting in the same cycle still wins
      state_d.pend = state_q.pend & ~bus_wdata;
    end
    if (bus_valid && bus_write && hit_set)
    begin
      state_d.pend = state_d.pend | bus_wdata;
    end
    state_d.pend = state_d.pend | irq_pend_set;
    if (bus_valid && bus_write && hit_prio)
    begin
      for (int f = 0; f < `IPP_FIELDS_PER_REG; f++)
      begin
        // only the top two bits of each byte are stored
        state_d.prio[prio_idx][f] =
          bus_wdata[f*`IPP_BYTE_WIDTH+`IPP_PRIO_LSB +: `IPP_PRIO_WIDTH];
      end
    end
    if (bus_valid)
    begin
      state_d.ready = 1'b1;
      state_d.err   = !(hit_set || hit_clr || hit_prio);
      if (!bus_write)
      begin
        if (hit_set || hit_clr)
        begin
          state_d.rdata = state_q.pend;
        end
        else if (hit_prio)
        begin
          state_d.rdata = prio_word[prio_idx];
        end
        else
        begin
          state_d.rdata = `IPP_RDATA_RESET;
        end
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_q.pend  <= `IPP_PEND_RESET;
      state_q.rdata <= `IPP_RDATA_RESET;
      state_q.ready <= 1'b0;
      state_q.err   <= 1'b0;
      for (int r = 0; r < `IPP_NUM_PRIO_REGS; r++)
      begin
        for (int f = 0; f < `IPP_FIELDS_PER_REG; f++)
        begin
          state_q.prio[r][f] <= `IPP_PRIO_RESET;
        end
      end
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign bus_rdata = state_q.rdata;
  assign bus_ready = state_q.ready;
  assign bus_err   = state_q.err;
  assign pending   = state_q.pend;

endmodule : ipp_regs
`default_nettype wire

// ===== ipp_cfg.svh
// addresses, field positions and reset values of the pending and priority registers
`ifndef IPP_CFG_SVH
`define IPP_CFG_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define IPP_PEND_SET_ADDR   32'hE000E200
`define IPP_PEND_CLR_ADDR   32'hE000E280
`define IPP_PRIO_BASE_ADDR  32'hE000E400
`define IPP_PRIO_LAST_ADDR  32'hE000E41C

// ----------------------------------------
// field layout
// ----------------------------------------
`define IPP_NUM_IRQ         32
`define IPP_NUM_PRIO_REGS   8
`define IPP_FIELDS_PER_REG  4
`define IPP_PRIO_WIDTH      2
`define IPP_PRIO_LSB        6
`define IPP_BYTE_WIDTH      8
`define IPP_PRIO_IDX_LSB    2
`define IPP_PRIO_IDX_MSB    4

// ----------------------------------------
// reset values
// ----------------------------------------
`define IPP_PEND_RESET      32'h00000000
`define IPP_PRIO_RESET      2'h0
`define IPP_RDATA_RESET     32'h00000000

`endif

// ===== ipp_pkg.sv
// types shared by the pending and priority register block
`default_nettype none
`include "ipp_cfg.svh"

package ipp_pkg;

  typedef logic [`IPP_NUM_IRQ-1:0]    ipp_word_t;
  typedef logic [`IPP_PRIO_WIDTH-1:0] ipp_prio_t;

  // all state of the register block
  typedef struct packed {
    ipp_word_t                                              pend;
    ipp_prio_t [`IPP_NUM_PRIO_REGS-1:0][`IPP_FIELDS_PER_REG-1:0] prio;
    ipp_word_t                                              rdata;
    logic                                                   ready;
    logic                                                   err;
  } ipp_state_s;

endpackage : ipp_pkg
`default_nettype wire

// ===== ipp_regs_assertions.sv
// assertions on the pending and priority register port
`timescale 1ns/1ns
`default_nettype none
module ipp_regs_assertions (
  input wire logic        mclk, rst, bus_valid, bus_write, bus_ready, bus_err,
  input wire logic [31:0] bus_addr, bus_wdata, bus_rdata, irq_pend_set, pending,
  input wire logic [63:0] priority_flat
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire       ws = bus_valid && bus_write && bus_addr == 32'hE000E200;
  wire       wc = bus_valid && bus_write && bus_addr == 32'hE000E280;
  wire       rp = bus_valid && !bus_write && bus_addr[31:8] == 24'hE000E2 && bus_addr[6:0] == 7'h0;
  wire       pr = bus_valid && bus_addr[31:5] == 27'h7000720 && bus_addr[1:0] == 2'h0;
  wire [7:0] pw = {bus_wdata[31:30], bus_wdata[23:22], bus_wdata[15:14], bus_wdata[7:6]};
  chk_ready_answer: assert property (bus_valid |=> bus_ready) else $error("no answer");
  chk_mapped_ok: assert property (ws || wc || rp || pr |=> !bus_err) else $error("err");
  chk_set_write:
    assert property (ws |=> pending == ($past(pending) | $past(bus_wdata) | $past(irq_pend_set)))
    else $error("set write");
  chk_clr_write:
    assert property (wc |=> pending == ($past(pending) & ~$past(bus_wdata) | $past(irq_pend_set)))
    else $error("clear write");
  chk_pend_read: assert property (rp |=> bus_rdata == $past(pending))
    else $error("pending read");
  chk_prio_rsvd: assert property (pr && !bus_write |=> (bus_rdata & 32'h3F3F3F3F) == 32'h0)
    else $error("reserved bits");
  chk_prio_write:
    assert property (pr && bus_write |=> priority_flat[$past(bus_addr[4:2]) * 8 +: 8] == $past(pw))
    else $error("priority write");
  chk_reset_zero: assert property ($fell(rst) |-> pending == 32'h0 && priority_flat == 64'h0)
    else $error("reset value");
endmodule : ipp_regs_assertions
bind ipp_regs ipp_regs_assertions ipp_regs_assertions_inst (
  .mclk(mclk), .rst(rst), .bus_valid(bus_valid), .bus_write(bus_write), .bus_ready(bus_ready),
  .bus_err(bus_err), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
  .irq_pend_set(irq_pend_set), .pending(pending), .priority_flat(priority_flat)
);
`default_nettype wire

// ===== ipp_core_model.sv
// bus master model of the core on the private peripheral bus
`timescale 1ns/1ns
`default_nettype none
module ipp_core_model (
  input  wire logic        mclk, bus_ready, bus_err,
  input  wire logic [31:0] bus_rdata,
  output var  logic        bus_valid, bus_write,
  output var  logic [31:0] bus_addr, bus_wdata
);
  initial {bus_valid, bus_write, bus_addr, bus_wdata} = '0;
  task automatic acc(input logic w, input logic [31:0] a, d,
                     output logic [63:0] r, output logic ok);
    @(posedge mclk);
    {bus_valid, bus_write, bus_addr, bus_wdata} <= {1'b1, w, a, d};
    @(posedge mclk);
    {bus_valid, bus_addr, bus_wdata} <= {1'b0, ~a, ~d}; // inverse, so a stale copy never passes
    for (int i = 0; i < 3 && !bus_ready; i++) @(posedge mclk);
    ok = bus_ready;
    r = {31'h0, bus_err, bus_rdata};
  endtask : acc
endmodule : ipp_core_model
`default_nettype wire

// ===== tb_irq_pending_priority_regs.sv
// self-checking bench for the pending and priority registers
`timescale 1ns/1ns
`default_nettype none
module tb_irq_pending_priority_regs;
  logic        mclk = 1'b0, rst = 1'b1, bus_valid, bus_write, bus_ready, bus_err, ok;
  logic [31:0] bus_addr, bus_wdata, bus_rdata, pending, d, irq_pend_set = '0;
  logic [63:0] priority_flat, r, pf;
  int          failures, n_compared;
  ipp_regs ipp_regs_inst (
    .mclk(mclk), .rst(rst), .bus_valid(bus_valid), .bus_write(bus_write),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_ready(bus_ready), .bus_err(bus_err), .irq_pend_set(irq_pend_set),
    .pending(pending), .priority_flat(priority_flat)
  );
  ipp_core_model ipp_core_model_inst (
    .mclk(mclk), .bus_ready(bus_ready), .bus_err(bus_err), .bus_rdata(bus_rdata),
    .bus_valid(bus_valid), .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata)
  );
  initial forever #4 mclk = ~mclk;
  task automatic chk(input string s, input logic [63:0] v, e);
    n_compared++;
    if (v !== e) failures++;
    if (v !== e) $display("CHECK FAILED %s exp %h seen %h", s, e, v);
  endtask : chk
  task automatic tally_and_finish;
    $display("compared %0d failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic rw(input logic w, input logic [31:0] a, v);
    ipp_core_model_inst.acc(w, a, v, r, ok);
    if (!ok) failures++;
    if (!ok) tally_and_finish();
  endtask : rw
  initial
  begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 32; i++)
    begin
      rw(1'b1, 32'hE000E200, 32'h1 << i);
      chk("pending", pending, (64'h2 << i) - 64'h1);
    end
    rw(1'b1, 32'hE000E280, 32'hFFFFFFFE);
    rw(1'b0, 32'hE000E200, 32'h0);
    chk("set read", r, 64'h1);
    $display("test set and clear done");
    for (int n = 0; n < 8; n++)
    begin
      d = 32'h3F7FBFFF ^ {4{n[1:0], 6'h0}};
      rw(1'b1, 32'hE000E400 + 32'(4 * n), d);
      rw(1'b0, 32'hE000E400 + 32'(4 * n), 32'h0);
      chk("prio read", r, {32'h0, d & 32'hC0C0C0C0});
      pf[8 * n +: 8] = {d[31:30], d[23:22], d[15:14], d[7:6]};
    end
    rw(1'b1, 32'hE000E401, 32'hFFFFFFFF);
    chk("misaligned", r, 64'h100000000);
    chk("prio flat", priority_flat, pf);
    $display("test priority done");
    irq_pend_set <= 32'h00000030;
    rw(1'b1, 32'hE000E280, 32'h00000011);
    irq_pend_set <= 32'h00000000;
    rw(1'b0, 32'hE000E280, 32'h0);
    chk("clear read", r, 64'h30);
    rw(1'b1, 32'hE000E200, 32'hA5A50000);
    chk("pending", pending, 64'hA5A50030);
    $display("test clear register done");
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk("reset pending", pending, 64'h0);
    chk("reset prio", priority_flat, 64'h0);
    rw(1'b0, 32'hE000E41C, 32'h0);
    chk("reset prio read", r, 64'h0);
    $display("test reset done");
    tally_and_finish();
  end
endmodule : tb_irq_pending_priority_regs
`default_nettype wire
